// File: verilog/hbu_pkg.sv
// package of constants and carrier types for the hardware breakpoint unit
//
// Behaviour
// [R1] two instruction, two data 32-bit rw registers
// [R2] instruction break taken before target executes
// [R3] compare raw register values, no tag merge
// [R4] address bits 31:1, bit 1 ignored word mode
// [R5] bit 0 enables instruction comparator, reset disabled
// [R6] instruction hit writes entry cause 001
// [R7] control bit 8 selects mask or breakpoint
// [R8] bits 1:0 set access type of a
// [R9] bits 3:2 set type of b, unused masking
// [R10] mask bits excluded, only while a enabled
// [R11] b breakpoint matches independently of a
// [R12] fire on type match and any-byte address
// [R13] preload and coproc 7-10 ops never fire
// [R14] swap and swap byte count as stores
// [R15] unaligned access compared on aligned word
// [R16] data break after access, before next instruction
// [R17] data break writes entry cause 010
// [R18] data break link equals next pc plus 4
// [R19] soft break nop unless status bit 31 set
// [R20] software writes data regs only while disabled
// [R21] handler disables instruction break before return
// [R22] no instruction breaks while debug globally off; here instruction comparators ignore status bit 31
// [R23] monitor mode: data abort or prefetch abort
// [R24] both data comparators give one exception
// [R25] control reserved bits read zero, reset zero
package hbu_pkg;

  // ---------------------------------------------------------------
  // register map (word offsets chosen for this block)
  // ---------------------------------------------------------------
  localparam logic [3:0]  ADDR_IBRK_A    = 4'h0;
  localparam logic [3:0]  ADDR_IBRK_B    = 4'h1;
  localparam logic [3:0]  ADDR_DBRK_A    = 4'h2;
  localparam logic [3:0]  ADDR_DBRK_B    = 4'h3;
  localparam logic [3:0]  ADDR_DCTRL     = 4'h4;
  localparam logic [3:0]  ADDR_DSTAT     = 4'h5;
  localparam logic [3:0]  ADDR_LINK      = 4'h6;

  // ---------------------------------------------------------------
  // field positions and values
  // ---------------------------------------------------------------
  localparam int          IBRK_EN_BIT    = 0;
  localparam int          DCTRL_MODE_BIT = 8;
  localparam logic [31:0] DCTRL_WMASK    = 32'h0000010F;
  localparam logic [31:0] DCTRL_RESET    = 32'h00000000;
  localparam int          DSTAT_GE_BIT   = 31;
  localparam int          DSTAT_MON_BIT  = 30;
  localparam logic [31:0] DSTAT_WMASK    = 32'hC0000000;
  localparam logic [31:0] DSTAT_RESET    = 32'h00000000;
  localparam logic [2:0]  CAUSE_IBRK     = 3'h1;
  localparam logic [2:0]  CAUSE_DBRK     = 3'h2;
  localparam logic [2:0]  CAUSE_SBRK     = 3'h3;
  localparam logic [31:0] LINK_OFFSET    = 32'h00000004;
  localparam logic [31:0] WORD_ALIGN     = 32'hFFFFFFFC;
  localparam logic [31:0] HALF_ALIGN     = 32'hFFFFFFFE;
  localparam logic [3:0]  CP_OP_LO       = 4'h7;
  localparam logic [3:0]  CP_OP_HI       = 4'hA;

  // access type select encoding
  typedef enum logic [1:0] {
    ACC_OFF   = 2'b00,
    ACC_STORE = 2'b01,
    ACC_ANY   = 2'b10,
    ACC_LOAD  = 2'b11
  } hbu_acc_t;

  // one load/store from the pipeline
  typedef struct packed {
    logic        valid;
    logic        is_store;
    logic        is_swap;
    logic        is_preload;
    logic        is_cp_op;
    logic [3:0]  cp_reg;
    logic [1:0]  size_log2;
    logic [31:0] addr;
    logic [31:0] next_pc;
  } hbu_mem_t;

  // one fetch from the pipeline
  typedef struct packed {
    logic        valid;
    logic        compressed;
    logic        is_soft_brk;
    logic [31:0] addr;
  } hbu_fetch_t;

  // exception request to the core
  typedef struct packed {
    logic        take;
    logic        data_abort;
    logic        prefetch_abort;
    logic        halt_entry;
    logic [2:0]  cause;
    logic [31:0] link;
  } hbu_exc_t;

endpackage

// File: verilog/hbu_unit.sv
// hardware breakpoint comparators, control registers and debug entry
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module hbu_unit (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic [3:0]          reg_addr_i,
  input  wire logic [31:0]         reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic [31:0]              reg_rdata_o,
  input  wire hbu_pkg::hbu_fetch_t fetch_i,
  input  wire hbu_pkg::hbu_mem_t   mem_i,
  output logic                     fetch_block_o,
  output hbu_pkg::hbu_exc_t        exc_o,
  output logic [2:0]               entry_cause_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0] instr_brk_reg_a;
  logic [31:0] instr_brk_reg_b;
  logic [31:0] data_brk_addr_a;
  logic [31:0] data_brk_addr_or_mask_b;
  logic [31:0] data_brk_control;
  logic [31:0] debug_ctrl_status;
  logic [31:0] link_save;
  logic [2:0]  entry_cause;
  logic [31:0] rdata;
  logic        fetch_block;
  hbu_pkg::hbu_exc_t exc;

  logic [31:0] next_instr_brk_reg_a;
  logic [31:0] next_instr_brk_reg_b;
  logic [31:0] next_data_brk_addr_a;
  logic [31:0] next_data_brk_addr_or_mask_b;
  logic [31:0] next_data_brk_control;
  logic [31:0] next_debug_ctrl_status;
  logic [31:0] next_link_save;
  logic [2:0]  next_entry_cause;
  logic [31:0] next_rdata;
  logic        next_fetch_block;
  hbu_pkg::hbu_exc_t next_exc;

  logic        ibrk_hit;
  logic        sbrk_hit;
  logic        dbrk_hit;
  logic        hit_a;
  logic        hit_b;
  logic        mask_mode;
  logic        eligible;
  logic        eff_store;
  logic [31:0] acc_lo;
  logic [31:0] acc_hi;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // instruction compare; bit 0 is the enable, bit 1 dropped in word
  // mode so a word-aligned entry matches either halfword of the word
  function automatic logic ibrk_match(input logic [31:0] r,
                                      input logic [31:0] pc,
                                      input logic        half);
    logic [31:0] m;
    m = half ? hbu_pkg::HALF_ALIGN : hbu_pkg::WORD_ALIGN;
    ibrk_match = r[hbu_pkg::IBRK_EN_BIT] &&            // [R5]
                 ((r & m) == (pc & m));                // [R3] [R4]
  endfunction

  // access type filter against a two bit select
  function automatic logic acc_ok(input logic [1:0] sel,
                                  input logic       st);
    case (hbu_pkg::hbu_acc_t'(sel))
      hbu_pkg::ACC_STORE: acc_ok = st;
      hbu_pkg::ACC_ANY:   acc_ok = 1'b1;
      hbu_pkg::ACC_LOAD:  acc_ok = !st;
      default:            acc_ok = 1'b0;
    endcase
  endfunction

  // any byte in [lo,hi] equal to target under ignore mask; the
  // access never spans more than one word after alignment, so the
  // byte lane check reduces to word compare plus lane range
  function automatic logic addr_hit(input logic [31:0] tgt,
                                    input logic [31:0] ign,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    logic wmatch;
    wmatch = ((tgt[31:2] | ign[31:2]) == (lo[31:2] | ign[31:2]));
    addr_hit = wmatch &&
               ((tgt[1:0] | ign[1:0]) >= (lo[1:0] & ~ign[1:0])) &&
               ((tgt[1:0] & ~ign[1:0]) <= (hi[1:0] | ign[1:0]));
  endfunction

  // ---------------------------------------------------------------
  // comparators
  // ---------------------------------------------------------------
  always_comb begin
    mask_mode = data_brk_control[hbu_pkg::DCTRL_MODE_BIT];       // [R7]
    // preload hints and cache/tlb coprocessor ops never trap
    eligible  = mem_i.valid && !mem_i.is_preload &&              // [R13]
                !(mem_i.is_cp_op &&
                  mem_i.cp_reg >= hbu_pkg::CP_OP_LO &&
                  mem_i.cp_reg <= hbu_pkg::CP_OP_HI);
    eff_store = mem_i.is_store || mem_i.is_swap;                 // [R14]
    // unaligned accesses are compared on their containing word
    acc_lo    = ((mem_i.addr[1:0] & ((2'b01 << mem_i.size_log2) - 2'b01))
                 != 2'b00) ? (mem_i.addr & hbu_pkg::WORD_ALIGN)  // [R15]
                           : mem_i.addr;
    acc_hi    = (mem_i.size_log2 >= 2'd2) ? (acc_lo | 32'h00000003)
                : (acc_lo + ((32'h00000001 << mem_i.size_log2)
                             - 32'h00000001));
    hit_a     = eligible &&
                acc_ok(data_brk_control[1:0], eff_store) &&      // [R8]
                addr_hit(data_brk_addr_a,                        // [R12]
                         mask_mode ? data_brk_addr_or_mask_b     // [R10]
                                   : 32'h00000000,
                         acc_lo, acc_hi);
    hit_b     = eligible && !mask_mode &&                        // [R11]
                acc_ok(data_brk_control[3:2], eff_store) &&      // [R9]
                addr_hit(data_brk_addr_or_mask_b, 32'h00000000,
                         acc_lo, acc_hi);
    dbrk_hit  = hit_a || hit_b;                                  // [R24]
    ibrk_hit  = fetch_i.valid &&
                (ibrk_match(instr_brk_reg_a, fetch_i.addr,
                            fetch_i.compressed) ||
                 ibrk_match(instr_brk_reg_b, fetch_i.addr,
                            fetch_i.compressed));
    sbrk_hit  = fetch_i.valid && fetch_i.is_soft_brk &&
                debug_ctrl_status[hbu_pkg::DSTAT_GE_BIT];        // [R19]
  end

  // ---------------------------------------------------------------
  // registers and exception next state
  // ---------------------------------------------------------------
  // data breaks outrank fetch breaks, matching core priority order
  always_comb begin
    next_instr_brk_reg_a         = instr_brk_reg_a;
    next_instr_brk_reg_b         = instr_brk_reg_b;
    next_data_brk_addr_a         = data_brk_addr_a;
    next_data_brk_addr_or_mask_b = data_brk_addr_or_mask_b;
    next_data_brk_control        = data_brk_control;
    next_debug_ctrl_status       = debug_ctrl_status;
    next_link_save               = link_save;
    next_entry_cause             = entry_cause;
    next_rdata                   = 32'h00000000;
    next_exc                     = '0;
    // fetch stall is combinational-free: held one cycle behind hit
    next_fetch_block             = ibrk_hit || sbrk_hit;         // [R2]

    if (reg_wr_i) begin
      case (reg_addr_i)
        hbu_pkg::ADDR_IBRK_A: next_instr_brk_reg_a = reg_wdata_i; // [R1]
        hbu_pkg::ADDR_IBRK_B: next_instr_brk_reg_b = reg_wdata_i;
        hbu_pkg::ADDR_DBRK_A: next_data_brk_addr_a = reg_wdata_i;
        hbu_pkg::ADDR_DBRK_B: next_data_brk_addr_or_mask_b = reg_wdata_i;
        hbu_pkg::ADDR_DCTRL:
          next_data_brk_control = reg_wdata_i &
                                  hbu_pkg::DCTRL_WMASK;           // [R25]
        hbu_pkg::ADDR_DSTAT:
          next_debug_ctrl_status = reg_wdata_i & hbu_pkg::DSTAT_WMASK;
        default: ;
      endcase
    end

    if (reg_rd_i) begin
      case (reg_addr_i)
        hbu_pkg::ADDR_IBRK_A: next_rdata = instr_brk_reg_a;
        hbu_pkg::ADDR_IBRK_B: next_rdata = instr_brk_reg_b;
        hbu_pkg::ADDR_DBRK_A: next_rdata = data_brk_addr_a;
        hbu_pkg::ADDR_DBRK_B: next_rdata = data_brk_addr_or_mask_b;
        hbu_pkg::ADDR_DCTRL:  next_rdata = data_brk_control;
        hbu_pkg::ADDR_DSTAT:
          next_rdata = debug_ctrl_status | {29'h0, entry_cause};
        hbu_pkg::ADDR_LINK:   next_rdata = link_save;
        default:              next_rdata = 32'h00000000;
      endcase
    end

    if (dbrk_hit) begin
      // access already issued; core traps before the next instruction
      next_exc.take       = 1'b1;                                 // [R16]
      next_exc.cause      = hbu_pkg::CAUSE_DBRK;                  // [R17]
      next_exc.link       = mem_i.next_pc + hbu_pkg::LINK_OFFSET; // [R18]
      next_exc.data_abort = debug_ctrl_status[hbu_pkg::DSTAT_MON_BIT];
    end else if (ibrk_hit) begin
      next_exc.take       = 1'b1;
      next_exc.cause      = hbu_pkg::CAUSE_IBRK;                  // [R6]
      next_exc.link       = fetch_i.addr + hbu_pkg::LINK_OFFSET;
      next_exc.prefetch_abort =
        debug_ctrl_status[hbu_pkg::DSTAT_MON_BIT];                // [R23]
    end else if (sbrk_hit) begin
      next_exc.take       = 1'b1;
      next_exc.cause      = hbu_pkg::CAUSE_SBRK;
      next_exc.link       = fetch_i.addr + hbu_pkg::LINK_OFFSET;
      next_exc.prefetch_abort =
        debug_ctrl_status[hbu_pkg::DSTAT_MON_BIT];                // [R23]
    end
    next_exc.halt_entry = next_exc.take &&
                          !debug_ctrl_status[hbu_pkg::DSTAT_MON_BIT];
    if (next_exc.take) begin
      next_entry_cause = next_exc.cause;
      next_link_save   = next_exc.link;
    end
  end

  // register update; address registers reset to zero, enables off
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      instr_brk_reg_a         <= 32'h00000000;                  // [R5]
      instr_brk_reg_b         <= 32'h00000000;
      data_brk_addr_a         <= 32'h00000000;
      data_brk_addr_or_mask_b <= 32'h00000000;
      data_brk_control        <= hbu_pkg::DCTRL_RESET;          // [R25]
      debug_ctrl_status       <= hbu_pkg::DSTAT_RESET;
      link_save               <= 32'h00000000;
      entry_cause             <= 3'h0;
      rdata                   <= 32'h00000000;
      fetch_block             <= 1'b0;
      exc                     <= '0;
    end else begin
      instr_brk_reg_a         <= next_instr_brk_reg_a;
      instr_brk_reg_b         <= next_instr_brk_reg_b;
      data_brk_addr_a         <= next_data_brk_addr_a;
      data_brk_addr_or_mask_b <= next_data_brk_addr_or_mask_b;
      data_brk_control        <= next_data_brk_control;
      debug_ctrl_status       <= next_debug_ctrl_status;
      link_save               <= next_link_save;
      entry_cause             <= next_entry_cause;
      rdata                   <= next_rdata;
      fetch_block             <= next_fetch_block;
      exc                     <= next_exc;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o   = rdata;
  assign fetch_block_o = fetch_block;
  assign exc_o         = exc;
  assign entry_cause_o = entry_cause;

endmodule // hbu_unit

// File: bench/hbu_unit_chk.sv
// concurrent checks on the breakpoint unit ports
`timescale 1ns/1ps
module hbu_unit_chk (
  input wire logic                clk_i,
  input wire logic                rstn_i,
  input wire logic [3:0]          reg_addr_i,
  input wire logic                reg_rd_i,
  input wire logic [31:0]         reg_rdata_o,
  input wire hbu_pkg::hbu_fetch_t fetch_i,
  input wire hbu_pkg::hbu_mem_t   mem_i,
  input wire logic                fetch_block_o,
  input wire hbu_pkg::hbu_exc_t   exc_o,
  input wire logic [2:0]          entry_cause_o
);
  // ---------------------------------------------------------------
  // one clock domain, synchronous active-low reset
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // read data only stands in the cycle after a read strobe
  rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data seen without a read strobe");
  ctrl_rsvd_a: assert property (
    reg_rd_i && reg_addr_i == hbu_pkg::ADDR_DCTRL
    |=> (reg_rdata_o & ~hbu_pkg::DCTRL_WMASK) == 32'h0)
    else $error("reserved control bits read nonzero");
  cause_copy_a: assert property (
    exc_o.take |-> entry_cause_o == exc_o.cause)
    else $error("entry cause differs from exception cause");
  cause_hold_a: assert property (
    !exc_o.take |-> $stable(entry_cause_o))
    else $error("entry cause moved without an exception");
  preload_quiet_a: assert property (
    mem_i.valid && mem_i.is_preload && !fetch_i.valid |=> !exc_o.take)
    else $error("preload raised an exception");
  cp_op_a: assert property (
    mem_i.valid && mem_i.is_cp_op && !fetch_i.valid
    && mem_i.cp_reg inside {[4'h7:4'hA]} |=> !exc_o.take)
    else $error("coprocessor op raised an exception");
  data_link_a: assert property (
    exc_o.take && exc_o.cause == hbu_pkg::CAUSE_DBRK
    |-> exc_o.link == $past(mem_i.next_pc) + hbu_pkg::LINK_OFFSET)
    else $error("data break link wrong");
  abort_kind_a: assert property (
    exc_o.take && exc_o.cause == hbu_pkg::CAUSE_DBRK
    |-> !exc_o.prefetch_abort && (exc_o.data_abort ^ exc_o.halt_entry))
    else $error("data break delivered with wrong kind");
  fetch_kind_a: assert property (
    exc_o.take && exc_o.cause != hbu_pkg::CAUSE_DBRK
    |-> !exc_o.data_abort && (exc_o.prefetch_abort ^ exc_o.halt_entry))
    else $error("fetch break delivered with wrong kind");
  no_fetch_a: assert property (!fetch_i.valid |=> !fetch_block_o)
    else $error("fetch blocked without a fetch");
  block_take_a: assert property (fetch_block_o |-> exc_o.take)
    else $error("fetch blocked without an exception");
  idle_quiet_a: assert property (
    !fetch_i.valid && !mem_i.valid |=> !exc_o.take)
    else $error("exception with no fetch or access");

  // main scenarios reached
  c_ibrk: cover property (exc_o.take && exc_o.cause == 3'h1);
  c_dbrk: cover property (exc_o.take && exc_o.cause == 3'h2);
  c_sbrk: cover property (exc_o.take && exc_o.cause == 3'h3);
endmodule // hbu_unit_chk

bind hbu_unit hbu_unit_chk u_chk (.clk_i, .rstn_i, .reg_addr_i, .reg_rd_i,
  .reg_rdata_o, .fetch_i, .mem_i, .fetch_block_o, .exc_o, .entry_cause_o);

// File: bench/hbu_core_mdl.sv
// core pipeline model presenting fetches and load/stores
`timescale 1ns/1ps
module hbu_core_mdl (
  input  wire logic           clk_i,
  output hbu_pkg::hbu_fetch_t fetch_o,
  output hbu_pkg::hbu_mem_t   mem_o
);
  initial begin
    fetch_o = '0;
    mem_o = '0;
  end

  // each item stands one cycle; afterwards the fields flip so stale
  // values can never pass for a live request
  task automatic put(input hbu_pkg::hbu_fetch_t f,
                     input hbu_pkg::hbu_mem_t m);
    hbu_pkg::hbu_fetch_t fi;
    hbu_pkg::hbu_mem_t   mi;
    fi = ~f;
    fi.valid = 1'b0;
    mi = ~m;
    mi.valid = 1'b0;
    @(posedge clk_i);
    fetch_o <= f;
    mem_o <= m;
    @(posedge clk_i);
    fetch_o <= fi;
    mem_o <= mi;
  endtask
endmodule // hbu_core_mdl

// File: bench/hbu_unit_tb.sv
// self-checking testbench of the hardware breakpoint unit
`timescale 1ns/1ps
module hbu_unit_tb;
  logic                clk_i, rstn_i, reg_wr_i, reg_rd_i, fetch_block_o;
  logic [3:0]          reg_addr_i;
  logic [31:0]         reg_wdata_i, reg_rdata_o, brk, a, v;
  logic [2:0]          entry_cause_o;
  logic [1:0]          code;
  logic                st, mon;
  hbu_pkg::hbu_fetch_t fetch_i;
  hbu_pkg::hbu_mem_t   mem_i, m;
  hbu_pkg::hbu_exc_t   exc_o;
  int                  n_fail, check_count;

  hbu_unit DUT (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .fetch_i(fetch_i), .mem_i(mem_i),
    .fetch_block_o(fetch_block_o), .exc_o(exc_o),
    .entry_cause_o(entry_cause_o));
  hbu_core_mdl core (.clk_i(clk_i), .fetch_o(fetch_i), .mem_o(mem_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad, input logic [31:0] e, string nm);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(nm, e, reg_rdata_o);
  endtask

  // present one item and check the registered exception beside it
  // fetch breaks (instruction and soft) stall the fetch; the delivery
  // kind follows the monitor flag last written to the status register
  task automatic hit(input hbu_pkg::hbu_fetch_t f, hbu_pkg::hbu_mem_t mi,
                     input logic [2:0] c);
    logic [2:0] k;
    logic [2:0] g;
    k = (c == 3'h0) ? 3'h0 : (c == 3'h2) ? {mon, 1'b0, !mon}
                                         : {1'b0, mon, !mon};
    core.put(f, mi);
    #1 chk("take", {31'h0, c != 3'h0}, {31'h0, exc_o.take});
    g = {exc_o.data_abort, exc_o.prefetch_abort, exc_o.halt_entry};
    chk("block", {31'h0, c[0]}, {31'h0, fetch_block_o});
    chk("kind", {29'h0, k}, {29'h0, g});
    if (c != 3'h0) chk("cause", {29'h0, c}, {29'h0, entry_cause_o});
    if (c[0]) chk("ilink", f.addr + 32'h4, exc_o.link);
    if (c == 3'h2) chk("dlink", mi.next_pc + 32'h4, exc_o.link);
  endtask

  function automatic hbu_pkg::hbu_fetch_t ff(input logic [31:0] ad,
                                             input logic cmp, sb);
    ff = '{valid: 1'b1, compressed: cmp, is_soft_brk: sb, addr: ad};
  endfunction

  function automatic hbu_pkg::hbu_mem_t mm(input logic [31:0] ad,
                                           input logic s, sw, pl);
    mm = '0;
    mm.valid = 1'b1;
    mm.is_store = s;
    mm.is_swap = sw;
    mm.is_preload = pl;
    mm.size_log2 = 2'h2;
    mm.addr = ad;
    mm.next_pc = $urandom;
  endfunction

  // expected data hit for breakpoint a alone, word accesses only
  function automatic logic [2:0] exp_d(input logic [1:0] cd, logic s,
                                       input logic [31:0] ad, bk);
    logic ty;
    ty = (cd == 2'h1) ? s : (cd == 2'h2) ? 1'b1 : (cd == 2'h3) ? !s : 1'b0;
    exp_d = (ty && ((ad ^ bk) & 32'hFFFFFFFC) == 32'h0) ? 3'h2 : 3'h0;
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog well beyond the roughly 300 cycles the tests take
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    conclude();
  end

  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    mon = 1'b0;
    void'($urandom(74));
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(hbu_pkg::ADDR_DCTRL, 32'h0, "ctrl_reset");
    wr(hbu_pkg::ADDR_DCTRL, 32'hFFFFFFFF);
    rd(hbu_pkg::ADDR_DCTRL, 32'h0000010F, "ctrl_bits");
    rd(4'hF, 32'h0, "unmapped");
    wr(hbu_pkg::ADDR_DCTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wr(i[3:0], v);
      rd(i[3:0], v, "addr_reg");
    end
    wr(hbu_pkg::ADDR_DSTAT, 32'h80000000);
    wr(hbu_pkg::ADDR_IBRK_A, 32'h00001001);
    wr(hbu_pkg::ADDR_IBRK_B, 32'h00002000);
    hit(ff(32'h1000, 1'b0, 1'b0), '0, 3'h1);
    hit(ff(32'h1002, 1'b0, 1'b0), '0, 3'h1);
    hit(ff(32'h1002, 1'b1, 1'b0), '0, 3'h0);
    hit(ff(32'h2000, 1'b0, 1'b0), '0, 3'h0);
    wr(hbu_pkg::ADDR_IBRK_A, 32'h00001000);
    hit(ff(32'h1000, 1'b0, 1'b0), '0, 3'h0);
    hit(ff(32'h3000, 1'b0, 1'b1), '0, 3'h3);
    wr(hbu_pkg::ADDR_DSTAT, 32'h40000000);
    mon = 1'b1;
    hit(ff(32'h3000, 1'b0, 1'b1), '0, 3'h0);
    brk = $urandom;
    wr(hbu_pkg::ADDR_DBRK_A, brk);
    repeat (48) begin
      code = 2'($urandom);
      st = 1'($urandom);
      a = $urandom;
      if (a[31]) a = (brk & 32'hFFFFFFFC) | ($urandom & 32'h3);
      wr(hbu_pkg::ADDR_DCTRL, {30'h0, code});
      hit('0, mm(a, st, 1'b0, 1'b0), exp_d(code, st, a, brk));
    end
    wr(hbu_pkg::ADDR_DCTRL, 32'h00000003);
    hit('0, mm(brk, 1'b0, 1'b1, 1'b0), 3'h0);
    hit('0, mm(brk, 1'b0, 1'b0, 1'b1), 3'h0);
    m = mm(brk, 1'b0, 1'b0, 1'b0);
    m.is_cp_op = 1'b1;
    // neighbours 6 and 11 must still trap, only 7 to 10 are exempt
    for (int r = 6; r < 12; r++) begin
      m.cp_reg = r[3:0];
      hit('0, m, (r inside {[7:10]}) ? 3'h0 : 3'h2);
    end
    wr(hbu_pkg::ADDR_DCTRL, 32'h0);
    wr(hbu_pkg::ADDR_DBRK_B, 32'h000000F0);
    wr(hbu_pkg::ADDR_DSTAT, 32'h0);
    mon = 1'b0;
    wr(hbu_pkg::ADDR_DCTRL, 32'h00000102);
    hit('0, mm(brk ^ 32'h80, 1'b0, 1'b0, 1'b0), 3'h2);
    hit('0, mm(brk ^ 32'h100, 1'b0, 1'b0, 1'b0), 3'h0);
    wr(hbu_pkg::ADDR_DCTRL, 32'h0000010C);
    hit('0, mm(brk ^ 32'h80, 1'b0, 1'b0, 1'b0), 3'h0);
    wr(hbu_pkg::ADDR_DCTRL, 32'h0);
    wr(hbu_pkg::ADDR_DBRK_B, brk);
    wr(hbu_pkg::ADDR_DCTRL, 32'h0000000A);
    hit('0, mm(brk, 1'b1, 1'b0, 1'b0), 3'h2);
    @(posedge clk_i);
    #1 chk("single", 32'h0, {31'h0, exc_o.take});
    wr(hbu_pkg::ADDR_DCTRL, 32'h0000000C);
    hit('0, mm(brk, 1'b0, 1'b0, 1'b0), 3'h2);
    hit('0, mm(brk, 1'b1, 1'b0, 1'b0), 3'h0);
    conclude();
  end
endmodule // hbu_unit_tb
